/* File: fsdo_defines.svh */
// Register map, field positions, reset values and timing counts for the
// floppy status and drive output register bank.
// Assumes a 200 MHz controller clock and a 32-bit AXI4-Lite register bus.
`ifndef FSDO_DEFINES_SVH
`define FSDO_DEFINES_SVH

// Register indexes; byte address is four times the index
`define FSDO_STA_A_IDX 8'h00
`define FSDO_STA_B_IDX 8'h01
`define FSDO_DOC_IDX 8'h02
`define FSDO_CFG_IDX 8'h08
`define FSDO_STA_A_ADDR (`FSDO_STA_A_IDX << 2)
`define FSDO_STA_B_ADDR (`FSDO_STA_B_IDX << 2)
`define FSDO_DOC_ADDR (`FSDO_DOC_IDX << 2)
`define FSDO_CFG_ADDR (`FSDO_CFG_IDX << 2)

// Output register fields
`define FSDO_DOC_SOFT_RST_BIT 2
`define FSDO_DOC_DMA_BIT 3
`define FSDO_DOC_MOTOR_LSB 4
`define FSDO_DOC_RST 8'h00

// Configuration register fields
`define FSDO_CFG_ALT_BIT 0
`define FSDO_CFG_FOUR_BIT 1
`define FSDO_CFG_EN_BIT 2
`define FSDO_CFG_XCHG_BIT 3
`define FSDO_CFG_RST 4'h4

// Status fields
`define FSDO_STA_A_STEP_BIT 5
`define FSDO_STA_A_IRQ_BIT 7
`define FSDO_STA_B_RSVD 2'h3
`define FSDO_FLOAT_DATA 8'hff

// Bus responses
`define FSDO_RESP_OKAY 2'h0
`define FSDO_RESP_SLVERR 2'h2

// Latch strobe timing on motor one
`define FSDO_CLK_NS 5
`define FSDO_STB_MIN_NS 25
`define FSDO_STB_MAX_NS 80
`define FSDO_STB_DLY_CYC ((`FSDO_STB_MIN_NS + `FSDO_CLK_NS - 1) / `FSDO_CLK_NS)
`define FSDO_STB_WIDTH_CYC 4

`endif

/* File: fsdo_pkg.sv */
// Types shared by the floppy status and drive output register bank.
// Assumes fsdo_defines.svh is compiled with it.
`default_nettype none
package fsdo_pkg;

  // Latch strobe sequencer; one bit changes per step except HIGH back to IDLE
  typedef enum logic [1:0] {
    FSDO_STB_IDLE = 2'h0,
    FSDO_STB_WAIT = 2'h1,
    FSDO_STB_HIGH = 2'h3
  } fsdo_stb_type;

  // Whole state of the register bank
  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic aw_rdy;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic w_rdy;
    logic b_vld;
    logic [1:0] b_resp;
    logic ar_rdy;
    logic r_vld;
    logic [1:0] r_resp;
    logic [7:0] r_data;
    logic [7:0] doc;
    logic [3:0] cfg;
    logic rd_meta;
    logic rd_sync;
    logic rd_prev;
    logic wd_prev;
    logic par_rd;
    logic par_wd;
    logic [1:0] dsel_n;
    logic motor_zero_out_n;
    logic motor_one_out_n;
    logic soft_rst;
    logic dma_en;
    fsdo_stb_type stb;
    logic [4:0] stb_cnt;
  } fsdo_state_type;

endpackage
`default_nettype wire

/* File: fsdo_regs.sv */
// Status A, diagnostic status B and drive output registers of a floppy
// controller, reached over AXI4-Lite.
// Assumes step, write gate, write data and interrupt come from the command
// engine on I_CLK; read data arrives from the drive pin and is synchronised.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fsdo_defines.svh"
`default_nettype none

module fsdo_regs (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // AXI4-Lite write address and data
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // AXI4-Lite write response
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [7:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // Command engine signals
  input wire logic I_STEP_N,
  input wire logic I_WRITE_GATE_N,
  input wire logic I_WDATA_OUT_N,
  input wire logic I_IRQ,
  // Drive pin input
  input wire logic I_RDATA_N,
  // Drive interface outputs
  output logic [1:0] O_DRIVE_SEL_N,
  output logic O_MOTOR_ZERO_N,
  output logic O_MOTOR_ONE_N,
  // Controller control outputs
  output logic O_SOFT_RESET,
  output logic O_DMA_ENABLE
);

  fsdo_pkg::fsdo_state_type s_q;
  fsdo_pkg::fsdo_state_type s_d;

  // Motor enable bit of the drive picked by the select bits
  function automatic logic sel_motor(input logic [7:0] doc);
    sel_motor = doc[`FSDO_DOC_MOTOR_LSB + {30'h0, doc[1:0]}];
  endfunction

  // Word index of a byte address, or all ones when misaligned
  function automatic logic [7:0] word_idx(input logic [7:0] addr);
    if (addr[1:0] != 2'h0) begin
      word_idx = 8'hff;
    end else begin
      word_idx = {2'h0, addr[7:2]};
    end
  endfunction

  // Next state: bus slave, registers, status and drive outputs
  always_comb begin
    logic [7:0] widx;
    logic [7:0] ridx;
    logic [7:0] sta_a;
    logic [7:0] sta_b;
    logic wr_go;
    logic doc_wr;
    logic alt_mode;
    logic four;
    logic en;
    logic xchg;
    s_d = s_q;
    widx = word_idx(s_q.aw_addr);
    ridx = word_idx(I_ARADDR);
    sta_a = 8'h00;
    sta_b = 8'h00;
    wr_go = 1'b0;
    doc_wr = 1'b0;
    // Reads see the mode as it stood when the address was taken
    alt_mode = s_q.cfg[`FSDO_CFG_ALT_BIT];
    // Drive-side mode bits are refreshed once this cycle's write is known
    four = 1'b0;
    en = 1'b0;
    xchg = 1'b0;

    // Read data pin: two flops before any logic
    s_d.rd_meta = I_RDATA_N;
    s_d.rd_sync = s_q.rd_meta;
    s_d.rd_prev = s_q.rd_sync;
    s_d.wd_prev = I_WDATA_OUT_N;

    // Parity toggles on the rising, inactive-going edge
    // Parity is never cleared by a software reset or by a status read
    if (s_q.rd_sync && !s_q.rd_prev) begin
      s_d.par_rd = ~s_q.par_rd;
    end
    if (I_WDATA_OUT_N && !s_q.wd_prev) begin
      s_d.par_wd = ~s_q.par_wd;
    end

    // Write address and data are held until both are present
    if (I_AWVALID && s_q.aw_rdy) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = I_AWADDR;
    end
    if (I_WVALID && s_q.w_rdy) begin
      s_d.w_full = 1'b1;
      s_d.w_data = I_WDATA[7:0];
      s_d.w_lane0 = I_WSTRB[0];
    end
    if (s_q.b_vld && I_BREADY) begin
      s_d.b_vld = 1'b0;
    end

    // Perform the write once both halves are held and no answer is pending
    if (s_q.aw_full && s_q.w_full && !s_q.b_vld) begin
      wr_go = 1'b1;
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.b_vld = 1'b1;
      s_d.b_resp = `FSDO_RESP_OKAY;
    end
    if (wr_go) begin
      if (widx == `FSDO_DOC_IDX) begin
        doc_wr = 1'b1;
        if (s_q.w_lane0) begin
          s_d.doc = s_q.w_data;
        end
      end else if (widx == `FSDO_CFG_IDX) begin
        if (s_q.w_lane0) begin
          s_d.cfg = s_q.w_data[3:0];
        end
      end else if (widx == `FSDO_STA_A_IDX) begin
        // Status registers are read only: the write is dropped, not refused
        s_d.b_resp = `FSDO_RESP_OKAY;
      end else if (widx == `FSDO_STA_B_IDX) begin
        s_d.b_resp = `FSDO_RESP_OKAY;
      end else begin
        s_d.b_resp = `FSDO_RESP_SLVERR;
      end
    end
    s_d.aw_rdy = !s_d.aw_full;
    s_d.w_rdy = !s_d.w_full;

    // Drive outputs follow the configuration written in this same cycle,
    // so a mode change never leaves select and motor pins a cycle apart
    four = s_d.cfg[`FSDO_CFG_FOUR_BIT];
    en = s_d.cfg[`FSDO_CFG_EN_BIT];
    xchg = s_d.cfg[`FSDO_CFG_XCHG_BIT];

    // Status A: step and interrupt; other bits lie outside this bank
    sta_a[`FSDO_STA_A_STEP_BIT] = ~I_STEP_N;
    sta_a[`FSDO_STA_A_IRQ_BIT] = I_IRQ;

    // Status B assembled from output flops, the write gate input and parity bits
    sta_b[0] = ~s_q.motor_zero_out_n;
    sta_b[1] = ~s_q.motor_one_out_n;
    sta_b[2] = ~I_WRITE_GATE_N;
    sta_b[3] = s_q.par_rd;
    sta_b[4] = s_q.par_wd;
    sta_b[5] = s_q.doc[0];
    sta_b[7:6] = `FSDO_STA_B_RSVD;

    // Read channel: status reads only return data, nothing else moves
    // Legacy mode floats status reads; the low data byte then shows all ones
    if (s_q.r_vld && I_RREADY) begin
      s_d.r_vld = 1'b0;
    end
    if (I_ARVALID && s_q.ar_rdy) begin
      s_d.r_vld = 1'b1;
      s_d.r_resp = `FSDO_RESP_OKAY;
      if (ridx == `FSDO_STA_A_IDX) begin
        s_d.r_data = alt_mode ? sta_a : `FSDO_FLOAT_DATA;
      end else if (ridx == `FSDO_STA_B_IDX) begin
        s_d.r_data = alt_mode ? sta_b : `FSDO_FLOAT_DATA;
      end else if (ridx == `FSDO_DOC_IDX) begin
        s_d.r_data = s_q.doc;
      end else if (ridx == `FSDO_CFG_IDX) begin
        s_d.r_data = {4'h0, s_q.cfg};
      end else begin
        s_d.r_data = 8'h00;
        s_d.r_resp = `FSDO_RESP_SLVERR;
      end
    end
    s_d.ar_rdy = !s_d.r_vld;

    // Software reset follows the output register; DMA gate is its DMA bit or alternate mode
    s_d.soft_rst = ~s_d.doc[`FSDO_DOC_SOFT_RST_BIT];
    s_d.dma_en = s_d.cfg[`FSDO_CFG_ALT_BIT]
      | s_d.doc[`FSDO_DOC_DMA_BIT];

    // Drive select and motor outputs; a disabled controller drives nothing
    if (!en) begin
      s_d.dsel_n = 2'h3;
      s_d.motor_zero_out_n = 1'b1;
    end else if (four) begin
      // Encoded selects feed an outside decoder; motor zero carries the
      // enable bit of whichever drive the select bits name
      s_d.dsel_n = s_d.doc[1:0];
      s_d.motor_zero_out_n = ~sel_motor(s_d.doc);
    end else begin
      // Two drives: one-hot active-low select, direct motor bits
      s_d.dsel_n = 2'h3;
      s_d.motor_zero_out_n = ~s_d.doc[`FSDO_DOC_MOTOR_LSB];
      s_d.motor_one_out_n = ~s_d.doc[`FSDO_DOC_MOTOR_LSB + 1];
      if (s_d.doc[1:0] == 2'h0) begin
        s_d.dsel_n = 2'h2;
      end else if (s_d.doc[1:0] == 2'h1) begin
        s_d.dsel_n = 2'h1;
      end else if (s_d.doc[1:0] == 2'h2 && xchg) begin
        // Exchanged drive 2 takes over pin 0 and the motor zero output
        s_d.dsel_n = 2'h2;
        s_d.motor_zero_out_n = ~s_d.doc[`FSDO_DOC_MOTOR_LSB + 2];
      end
    end

    // Latch strobe on motor one after each output register write in four-drive mode.
    // The delay counts from the edge that loads the register, which keeps
    // the leading edge inside the allowed window. A write that lands while
    // a strobe runs does not start a second one.
    case (s_q.stb)
      fsdo_pkg::FSDO_STB_IDLE: begin
        if (doc_wr) begin
          s_d.stb = fsdo_pkg::FSDO_STB_WAIT;
          s_d.stb_cnt = 5'(`FSDO_STB_DLY_CYC - 1);
        end
      end
      fsdo_pkg::FSDO_STB_WAIT: begin
        if (s_q.stb_cnt == 5'h0) begin
          s_d.stb = fsdo_pkg::FSDO_STB_HIGH;
          s_d.stb_cnt = 5'(`FSDO_STB_WIDTH_CYC - 1);
        end else begin
          s_d.stb_cnt = s_q.stb_cnt - 5'h1;
        end
      end
      fsdo_pkg::FSDO_STB_HIGH: begin
        if (s_q.stb_cnt == 5'h0) begin
          s_d.stb = fsdo_pkg::FSDO_STB_IDLE;
        end else begin
          s_d.stb_cnt = s_q.stb_cnt - 5'h1;
        end
      end
      default: begin
        s_d.stb = fsdo_pkg::FSDO_STB_IDLE;
      end
    endcase
    // In four-drive mode motor one idles low and is high only while the
    // strobe stands; in two-drive mode the branch above has set it, and disabled it is held high
    if (en && four) begin
      s_d.motor_one_out_n = (s_d.stb == fsdo_pkg::FSDO_STB_HIGH);
    end else if (!en) begin
      s_d.motor_one_out_n = 1'b1;
    end
  end

  // State register; hardware reset loads constants only.
  // Synchroniser and edge flops reset to the idle high level of their
  // lines so that release of reset never looks like a data edge.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_q <= '0;
      s_q.aw_rdy <= 1'b1;
      s_q.w_rdy <= 1'b1;
      s_q.ar_rdy <= 1'b1;
      s_q.doc <= `FSDO_DOC_RST;
      s_q.cfg <= `FSDO_CFG_RST;
      s_q.rd_meta <= 1'b1;
      s_q.rd_sync <= 1'b1;
      s_q.rd_prev <= 1'b1;
      s_q.wd_prev <= 1'b1;
      s_q.dsel_n <= 2'h2;
      s_q.motor_zero_out_n <= 1'b1;
      s_q.motor_one_out_n <= 1'b1;
      s_q.soft_rst <= 1'b1;
      s_q.stb <= fsdo_pkg::FSDO_STB_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign O_AWREADY = s_q.aw_rdy;
  assign O_WREADY = s_q.w_rdy;
  assign O_BVALID = s_q.b_vld;
  assign O_BRESP = s_q.b_resp;
  assign O_ARREADY = s_q.ar_rdy;
  assign O_RVALID = s_q.r_vld;
  assign O_RRESP = s_q.r_resp;
  assign O_RDATA = {24'h0, s_q.r_data};
  assign O_DRIVE_SEL_N = s_q.dsel_n;
  assign O_MOTOR_ZERO_N = s_q.motor_zero_out_n;
  assign O_MOTOR_ONE_N = s_q.motor_one_out_n;
  assign O_SOFT_RESET = s_q.soft_rst;
  assign O_DMA_ENABLE = s_q.dma_en;

endmodule // fsdo_regs

`default_nettype wire

/* File: fsdo_drive_model.sv */
// Behavioural floppy drive seen from the drive pins of the register bank.
// Assumes the bench asks for read data bursts with i_go and i_bits.
`timescale 1ns/1ps
`default_nettype none
module fsdo_drive_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Drive pins from the bank, and the four-drive flag from the bench
  input wire logic i_m0_n,
  input wire logic i_m1_n,
  input wire logic i_four,
  // Bench requests
  input wire logic i_go,
  input wire logic [3:0] i_bits,
  // Read data pin, idles high through its pull-up
  output logic o_rdata_n
);
  logic [5:0] cnt_q;
  logic spin;

  // Four-drive decode spins only on the documented motor pattern
  assign spin = i_four ? !i_m0_n : (!i_m0_n || !i_m1_n);

  // Each bit is a two-cycle low pulse, nothing sent unless spinning
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 6'h0;
      o_rdata_n <= 1'b1;
    end else if (i_go && spin) begin
      cnt_q <= {i_bits, 2'h0};
    end else if (cnt_q != 6'h0) begin
      cnt_q <= cnt_q - 6'h1;
      o_rdata_n <= !cnt_q[1];
    end else begin
      o_rdata_n <= 1'b1;
    end
  end
endmodule // fsdo_drive_model
`default_nettype wire

/* File: fsdo_regs_chk.sv */
// Concurrent checks on the ports of the floppy status and output bank.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "fsdo_defines.svh"
module fsdo_regs_chk (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Bus signals watched
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic O_RVALID,
  input wire logic [31:0] O_RDATA,
  input wire logic O_BVALID,
  // Engine inputs and drive outputs
  input wire logic I_STEP_N,
  input wire logic I_IRQ,
  input wire logic [1:0] O_DRIVE_SEL_N,
  input wire logic O_MOTOR_ZERO_N,
  input wire logic O_MOTOR_ONE_N,
  input wire logic O_SOFT_RESET,
  input wire logic O_DMA_ENABLE
);
  logic [7:0] ra_q;
  logic bv_q;
  logic [4:0] cnt_q;

  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  // Read address, and cycles since the last write completed
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ra_q <= 8'h0;
      bv_q <= 1'b0;
      cnt_q <= 5'h1f;
    end else begin
      if (I_ARVALID && O_ARREADY) ra_q <= I_ARADDR;
      bv_q <= O_BVALID;
      if (O_BVALID && !bv_q) cnt_q <= 5'h1;
      else if (cnt_q != 5'h1f) cnt_q <= cnt_q + 5'h1;
    end
  end

  sequence s_rd_a; $rose(O_RVALID) && ra_q == `FSDO_STA_A_ADDR; endsequence
  sequence s_rd_b; $rose(O_RVALID) && ra_q == `FSDO_STA_B_ADDR; endsequence
  sequence s_wr; $rose(O_BVALID); endsequence
  sequence s_stb; $rose(O_MOTOR_ONE_N) && !$rose(O_BVALID); endsequence

  property p_sta_a;
    s_rd_a |-> O_RDATA[7:0] == 8'hff ||
      (O_RDATA[5] == !$past(I_STEP_N) && O_RDATA[7] == $past(I_IRQ));
  endproperty
  a_sta_a: assert property (p_sta_a) else $error("status a");
  property p_rsvd; s_rd_b |-> O_RDATA[7:6] == 2'h3; endproperty
  a_rsvd: assert property (p_rsvd) else $error("status b top bits");
  property p_mtr;
    s_rd_b |-> O_RDATA[7:0] == 8'hff || O_RDATA[1:0] ==
      ~{$past(O_MOTOR_ONE_N), $past(O_MOTOR_ZERO_N)};
  endproperty
  a_mtr: assert property (p_mtr) else $error("motor status bits");
  property p_soft; $changed(O_SOFT_RESET) |-> s_wr; endproperty
  a_soft: assert property (p_soft) else $error("soft reset moved");
  property p_sel; $changed(O_DRIVE_SEL_N) |-> s_wr; endproperty
  a_sel: assert property (p_sel) else $error("select moved");
  property p_m0; $changed(O_MOTOR_ZERO_N) |-> s_wr; endproperty
  a_m0: assert property (p_m0) else $error("motor zero moved");
  property p_dma; $changed(O_DMA_ENABLE) |-> s_wr; endproperty
  a_dma: assert property (p_dma) else $error("dma gate moved");
  property p_stb_dly; s_stb |-> cnt_q >= 5'h5 && cnt_q <= 5'h10; endproperty
  a_stb_dly: assert property (p_stb_dly) else $error("strobe delay");
  property p_stb_len;
    s_stb |-> O_MOTOR_ONE_N [*4] ##1 !O_MOTOR_ONE_N;
  endproperty
  a_stb_len: assert property (p_stb_len) else $error("strobe width");
endmodule // fsdo_regs_chk

bind fsdo_regs fsdo_regs_chk fsdo_regs_chk_inst (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY), .I_ARADDR(I_ARADDR), .O_RVALID(O_RVALID),
  .O_RDATA(O_RDATA), .O_BVALID(O_BVALID), .I_STEP_N(I_STEP_N),
  .I_IRQ(I_IRQ), .O_DRIVE_SEL_N(O_DRIVE_SEL_N),
  .O_MOTOR_ZERO_N(O_MOTOR_ZERO_N), .O_MOTOR_ONE_N(O_MOTOR_ONE_N),
  .O_SOFT_RESET(O_SOFT_RESET), .O_DMA_ENABLE(O_DMA_ENABLE));
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the floppy status and drive output bank.
// Assumes the drive model on the pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "fsdo_defines.svh"
module tb;
  logic I_CLK, I_RST_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [7:0] I_AWADDR, I_ARADDR;
  logic [31:0] I_WDATA, O_RDATA, rd;
  logic [3:0] I_WSTRB, nbits;
  logic [1:0] O_BRESP, O_RRESP, O_DRIVE_SEL_N, rsp;
  logic I_STEP_N, I_WRITE_GATE_N, I_WDATA_OUT_N, I_IRQ, I_RDATA_N;
  logic O_MOTOR_ZERO_N, O_MOTOR_ONE_N, O_SOFT_RESET, O_DMA_ENABLE;
  logic four_mode, go;
  int fail_count, n_compared, cyc;

  fsdo_regs fsdo_regs_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_AWADDR(I_AWADDR),
    .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .I_WDATA(I_WDATA),
    .I_WSTRB(I_WSTRB), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
    .O_BRESP(O_BRESP), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
    .I_ARADDR(I_ARADDR), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
    .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .I_STEP_N(I_STEP_N),
    .I_WRITE_GATE_N(I_WRITE_GATE_N), .I_WDATA_OUT_N(I_WDATA_OUT_N),
    .I_IRQ(I_IRQ), .I_RDATA_N(I_RDATA_N), .O_DRIVE_SEL_N(O_DRIVE_SEL_N),
    .O_MOTOR_ZERO_N(O_MOTOR_ZERO_N), .O_MOTOR_ONE_N(O_MOTOR_ONE_N),
    .O_SOFT_RESET(O_SOFT_RESET), .O_DMA_ENABLE(O_DMA_ENABLE));
  fsdo_drive_model fsdo_drive_model_inst (.i_clk(I_CLK), .i_rst_n(I_RST_N),
    .i_m0_n(O_MOTOR_ZERO_N), .i_m1_n(O_MOTOR_ONE_N), .i_four(four_mode),
    .i_go(go), .i_bits(nbits), .o_rdata_n(I_RDATA_N));

  // Clock at 200 MHz
  initial begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write: address and data offered together, each released when taken
  // Response ready stays high between calls, as does read data ready
  task automatic axw(input logic [7:0] a, d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    I_AWADDR <= a;
    I_WDATA <= {24'h0, d};
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    forever begin
      @(posedge I_CLK);
      if (O_BVALID === 1'b1) break;
      if (aw && O_AWREADY === 1'b1) begin
        aw = 1'b0;
        I_AWVALID <= 1'b0;
      end
      if (w && O_WREADY === 1'b1) begin
        w = 1'b0;
        I_WVALID <= 1'b0;
      end
    end
    r = O_BRESP;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    logic ar;
    ar = 1'b1;
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    forever begin
      @(posedge I_CLK);
      if (O_RVALID === 1'b1) break;
      if (ar && O_ARREADY === 1'b1) begin
        ar = 1'b0;
        I_ARVALID <= 1'b0;
      end
    end
    d = O_RDATA;
    r = O_RRESP;
  endtask

  task automatic wr(input logic [7:0] a, d);
    axw(a, d, rsp);
    chk("bresp", {30'h0, rsp}, 32'h0);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, e);
    axr(a, rd, rsp);
    chk(nm, rd, {24'h0, e});
  endtask

  // Selects, motor zero, motor one, soft reset as one word
  task automatic pins(input logic [4:0] e);
    chk("pins", {27'h0, O_DRIVE_SEL_N, O_MOTOR_ZERO_N, O_MOTOR_ONE_N,
      O_SOFT_RESET}, {27'h0, e});
  endtask

  // Cycles of latch strobe after a write
  task automatic stb(input int e);
    int n;
    n = 0;
    repeat (12) begin
      @(posedge I_CLK);
      if (O_MOTOR_ONE_N === 1'b1) n++;
    end
    chk("strobe", n, e);
  endtask

  task automatic t_reset;
    pins(5'h17);
    chk("dma", {31'h0, O_DMA_ENABLE}, 32'h0);
    rdc("doc", `FSDO_DOC_ADDR, 8'h00);
    rdc("float_a", `FSDO_STA_A_ADDR, 8'hff);
    rdc("float_b", `FSDO_STA_B_ADDR, 8'hff);
  endtask

  task automatic t_two;
    wr(`FSDO_DOC_ADDR, 8'h1c);
    pins(5'h12);
    wr(`FSDO_DOC_ADDR, 8'h08);
    pins(5'h17);
    chk("dma", {31'h0, O_DMA_ENABLE}, 32'h1);
    wr(`FSDO_DOC_ADDR, 8'h04);
    chk("dma", {31'h0, O_DMA_ENABLE}, 32'h0);
    wr(`FSDO_DOC_ADDR, 8'h2d);
    pins(5'h0c);
    rdc("doc", `FSDO_DOC_ADDR, 8'h2d);
  endtask

  task automatic t_status;
    wr(`FSDO_CFG_ADDR, 8'h05);
    chk("dma", {31'h0, O_DMA_ENABLE}, 32'h1);
    I_STEP_N <= 1'b0;
    I_IRQ <= 1'b1;
    I_WRITE_GATE_N <= 1'b0;
    nbits <= 4'h3;
    go <= 1'b1;
    I_WDATA_OUT_N <= 1'b0;
    @(posedge I_CLK);
    go <= 1'b0;
    I_WDATA_OUT_N <= 1'b1;
    repeat (24) @(posedge I_CLK);
    rdc("sta_a", `FSDO_STA_A_ADDR, 8'ha0);
    rdc("sta_b", `FSDO_STA_B_ADDR, 8'hfe);
    rdc("sta_b", `FSDO_STA_B_ADDR, 8'hfe);
    pins(5'h0c);
    I_STEP_N <= 1'b1;
    I_IRQ <= 1'b0;
    @(posedge I_CLK);
    rdc("sta_a", `FSDO_STA_A_ADDR, 8'h00);
  endtask

  task automatic t_four;
    wr(`FSDO_CFG_ADDR, 8'h06);
    four_mode <= 1'b1;
    stb(0);
    wr(`FSDO_DOC_ADDR, 8'h8f);
    pins(5'h18);
    stb(4);
    wr(`FSDO_DOC_ADDR, 8'h3f);
    pins(5'h1c);
    stb(4);
    wr(`FSDO_DOC_ADDR, 8'h4e);
    pins(5'h10);
    stb(4);
  endtask

  task automatic t_bad;
    axw(8'h10, 8'h55, rsp);
    chk("bresp_bad", {30'h0, rsp}, {30'h0, `FSDO_RESP_SLVERR});
    axr(8'h10, rd, rsp);
    chk("rresp_bad", {30'h0, rsp}, {30'h0, `FSDO_RESP_SLVERR});
    chk("rdata_bad", rd, 32'h0);
    wr(`FSDO_STA_A_ADDR, 8'h55);
    rdc("doc", `FSDO_DOC_ADDR, 8'h4e);
    I_WSTRB <= 4'he;
    wr(`FSDO_DOC_ADDR, 8'h00);
    I_WSTRB <= 4'hf;
    rdc("doc_strb", `FSDO_DOC_ADDR, 8'h4e);
    wr(`FSDO_CFG_ADDR, 8'h0c);
    pins(5'h12);
  endtask

  // Hardware reset in mid-run clears what a software reset keeps
  task automatic t_hwrst;
    I_RST_N <= 1'b0;
    repeat (2) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    pins(5'h17);
    rdc("doc_hw", `FSDO_DOC_ADDR, 8'h00);
    wr(`FSDO_CFG_ADDR, 8'h05);
    rdc("sta_b_hw", `FSDO_STA_B_ADDR, 8'hc4);
  endtask

  // Hardware reset, then the scenarios
  initial begin
    {I_RST_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 6'h0;
    {I_AWADDR, I_ARADDR, I_WDATA} = 48'h0;
    I_WSTRB = 4'hf;
    {I_STEP_N, I_WRITE_GATE_N, I_WDATA_OUT_N, I_IRQ} = 4'he;
    {four_mode, go, nbits} = 6'h0;
    {fail_count, n_compared, cyc} = 96'h0;
    repeat (20) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    t_reset();
    t_two();
    t_status();
    t_four();
    t_bad();
    t_hwrst();
    close_out();
  end
endmodule // tb
`default_nettype wire
